// ===== cispc_power_ctl.sv
/*
  Idle/stop power mode controller. Holds the power mode control register,
  gates the cpu clock and oscillator enables, and wakes on interrupt or reset.
  Assumes the core gives a write strobe, read strobe and instruction-complete
  pulse on clk_in; reset sources (pin, watchdog, clock loss) arrive as levels.
*/
`default_nettype none
module cispc_power_ctl
  import cispc_pkg::*;
(
  // clock and reset
  input  wire logic            clk_in,
  input  wire logic            rst_n_in,
  // special-function register port
  input  wire cispc_sfr_req_t  sfr_in,
  output logic [7:0]           sfr_rdata_out,
  output logic                 sfr_hit_out,
  // wake and reset sources
  input  wire logic            irq_enabled_pending_in,
  input  wire logic            ext_reset_n_pin_in,
  input  wire logic            watchdog_unit_ovf_in,
  input  wire logic            clock_loss_detector_fire_in,
  // gating and status
  output cispc_gate_t          gate_out,
  output cispc_mode_t          mode_out,
  output logic                 core_reset_out,
  output logic [15:0]          fetch_vec_out,
  output logic                 irq_wake_out
);
  // ==========================================================
  // pin synchroniser
  logic rst_pin_s1, rst_pin_s2;
  always_ff @(posedge clk_in) begin
    rst_pin_s1 <= ext_reset_n_pin_in;
    rst_pin_s2 <= rst_pin_s1;
  end

  // ==========================================================
  // reset sources
  logic any_reset;
  assign any_reset = !rst_n_in || !rst_pin_s2 || watchdog_unit_ovf_in
                     || clock_loss_detector_fire_in;

  // ==========================================================
  // mode request latch: takes effect once the writing instruction completes
  logic        wr_hit;
  logic        req_idle, req_stop;
  cispc_mode_t mode, next_mode;
  assign wr_hit = sfr_in.wr && (sfr_in.addr == CISPC_PMC_ADDR);

  always_ff @(posedge clk_in) begin
    if (any_reset) begin
      req_idle <= 1'b0;
      req_stop <= 1'b0;
    end else if (wr_hit) begin
      req_idle <= sfr_in.wdata[CISPC_IDLE_BIT];
      req_stop <= sfr_in.wdata[CISPC_STOP_BIT];
    end else if (sfr_in.instr_done) begin
      req_idle <= 1'b0;
      req_stop <= 1'b0;
    end
  end

  // ==========================================================
  // mode state machine
  always_comb begin
    next_mode = mode;
    case (mode)
      CISPC_RUN: begin
        if (sfr_in.instr_done && req_stop) begin
          next_mode = CISPC_STOP;
        end else if (sfr_in.instr_done && req_idle) begin
          next_mode = CISPC_IDLE;
        end
      end
      CISPC_IDLE: begin
        if (irq_enabled_pending_in) begin
          next_mode = CISPC_RUN;
        end
      end
      CISPC_STOP: begin
        next_mode = CISPC_STOP;  // interrupts ignored
      end
      default: begin
        next_mode = CISPC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (any_reset) begin
      mode <= CISPC_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      gate_out <= '{cpu_clk_en: 1'b1, osc_en: 1'b1, periph_clk_en: 1'b1,
                    irq_timer_en: 1'b1, cpu_wr_en: 1'b1};
    end else begin
      // clock loss detector is outside this gating and keeps running
      gate_out.cpu_clk_en    <= any_reset || (next_mode == CISPC_RUN);
      gate_out.cpu_wr_en     <= any_reset || (next_mode == CISPC_RUN);
      gate_out.osc_en        <= any_reset || (next_mode != CISPC_STOP);
      gate_out.periph_clk_en <= any_reset || (next_mode != CISPC_STOP);
      gate_out.irq_timer_en  <= any_reset || (next_mode != CISPC_STOP);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_out       <= CISPC_RUN;
      core_reset_out <= 1'b1;
      irq_wake_out   <= 1'b0;
    end else begin
      mode_out       <= any_reset ? CISPC_RUN : next_mode;
      core_reset_out <= any_reset;
      // core resumes at the instruction after the setting one on return
      irq_wake_out   <= !any_reset && mode == CISPC_IDLE && irq_enabled_pending_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fetch_vec_out <= CISPC_RESET_VEC;
    end else begin
      fetch_vec_out <= CISPC_RESET_VEC;
    end
  end

  // ==========================================================
  // read port: mode bits are write-only, reserved bits read zero
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sfr_rdata_out <= CISPC_PMC_RESET;
      sfr_hit_out   <= 1'b0;
    end else begin
      sfr_hit_out   <= (sfr_in.rd || sfr_in.wr) && sfr_in.addr == CISPC_PMC_ADDR;
      sfr_rdata_out <= CISPC_PMC_RESET;
    end
  end

  // ==========================================================
  // checks
  a_idle_entry_gate: assert property (@(posedge clk_in) disable iff (any_reset)
    (mode == CISPC_RUN && sfr_in.instr_done && req_idle && !req_stop)
      |=> (mode == CISPC_IDLE) && !gate_out.cpu_clk_en)
    else $error("idle entry did not gate cpu clock");
  a_idle_no_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode == CISPC_IDLE && !any_reset && !irq_enabled_pending_in) |=> !gate_out.cpu_wr_en)
    else $error("cpu write enabled during idle");
  a_idle_holds: assert property (@(posedge clk_in) disable iff (any_reset)
    (mode == CISPC_IDLE && !irq_enabled_pending_in) |=> mode == CISPC_IDLE)
    else $error("idle left without cause");
  sequence s_irq_wake;
    mode == CISPC_IDLE && irq_enabled_pending_in && !any_reset;
  endsequence
  a_irq_wake_run: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_irq_wake |=> irq_wake_out && gate_out.cpu_clk_en && mode == CISPC_RUN)
    else $error("interrupt wake did not restart cpu");
  a_reset_to_run: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    any_reset |=> core_reset_out && mode == CISPC_RUN && fetch_vec_out == CISPC_RESET_VEC)
    else $error("reset did not return to run");
  a_stop_sticky: assert property (@(posedge clk_in) disable iff (any_reset)
    (mode == CISPC_STOP) |=> mode == CISPC_STOP)
    else $error("stop left without reset");
  a_stop_gates: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode == CISPC_STOP && !any_reset) |=> !gate_out.osc_en && !gate_out.irq_timer_en)
    else $error("stop left clocks running");
  a_stop_wins: assert property (@(posedge clk_in) disable iff (any_reset)
    (mode == CISPC_RUN && sfr_in.instr_done && req_stop && req_idle) |=> mode == CISPC_STOP)
    else $error("stop did not win over idle");
  a_read_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    sfr_in.rd |=> sfr_rdata_out == 8'h00)
    else $error("mode bits read nonzero");
  a_loss_wakes: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode == CISPC_STOP && clock_loss_detector_fire_in) |=> mode == CISPC_RUN)
    else $error("clock loss reset did not end stop");

  // ==========================================================
  // gating levels per mode, wake pulse, reset paths, read data and address decode
  sequence s_stop_entry;
    mode == CISPC_RUN && sfr_in.instr_done && req_stop && !any_reset;
  endsequence
  // pin must stay low long enough to cross the synchroniser
  sequence s_pin_low_held;
    !ext_reset_n_pin_in ##1 !ext_reset_n_pin_in ##1 !ext_reset_n_pin_in;
  endsequence
  sequence s_pmc_access;
    (sfr_in.rd || sfr_in.wr) && sfr_in.addr == CISPC_PMC_ADDR;
  endsequence

  a_idle_cpu_gated: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode == CISPC_IDLE) |-> !gate_out.cpu_clk_en)
    else $error("cpu clock running in idle");

  a_idle_periph_live: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode == CISPC_IDLE) |-> gate_out.osc_en && gate_out.periph_clk_en && gate_out.irq_timer_en)
    else $error("peripheral clocks stopped in idle");

  a_idle_wr_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode == CISPC_IDLE) |-> !gate_out.cpu_wr_en)
    else $error("cpu write enable high in idle");

  a_run_clocks_on: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode == CISPC_RUN) |-> gate_out.cpu_clk_en && gate_out.cpu_wr_en && gate_out.osc_en)
    else $error("clocks gated in run");

  a_stop_clocks_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode == CISPC_STOP) |-> !gate_out.cpu_clk_en && !gate_out.osc_en && !gate_out.periph_clk_en)
    else $error("clocks running in stop");

  a_stop_timers_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode == CISPC_STOP) |-> !gate_out.irq_timer_en)
    else $error("timers running in stop");

  a_stop_entry_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_stop_entry |=> mode == CISPC_STOP && !gate_out.osc_en)
    else $error("stop entry did not halt oscillator");

  a_stop_irq_ignored: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode == CISPC_STOP && irq_enabled_pending_in && !any_reset) |=> mode == CISPC_STOP && !irq_wake_out)
    else $error("interrupt ended stop");

  a_stop_reset_exit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode == CISPC_STOP && any_reset) |=> mode == CISPC_RUN && core_reset_out
      && fetch_vec_out == CISPC_RESET_VEC)
    else $error("reset did not end stop");

  a_mode_out_track: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode_out == mode))
    else $error("mode output differs from mode");

  a_wake_one_cycle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    irq_wake_out |=> !irq_wake_out)
    else $error("wake pulse longer than one cycle");

  a_wake_in_run: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    irq_wake_out |-> mode == CISPC_RUN && gate_out.cpu_clk_en)
    else $error("wake pulse without run");

  a_reset_release: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !any_reset |=> !core_reset_out)
    else $error("core reset held without source");

  a_pin_reset_sync: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_pin_low_held |=> core_reset_out && mode == CISPC_RUN)
    else $error("pin reset not seen");

  a_wdog_ends_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode == CISPC_IDLE && watchdog_unit_ovf_in) |=> mode == CISPC_RUN && core_reset_out)
    else $error("watchdog reset did not end idle");

  a_loss_ends_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode == CISPC_IDLE && clock_loss_detector_fire_in) |=> mode == CISPC_RUN)
    else $error("clock loss reset did not end idle");

  a_rdata_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (sfr_rdata_out == 8'h00))
    else $error("read data nonzero");

  a_hit_decode: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_pmc_access |=> sfr_hit_out)
    else $error("access to control register not seen");

  a_hit_other: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !((sfr_in.rd || sfr_in.wr) && sfr_in.addr == CISPC_PMC_ADDR) |=> !sfr_hit_out)
    else $error("hit on other address");

  a_req_cleared: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    any_reset |=> !req_idle && !req_stop)
    else $error("reset left mode request pending");
endmodule : cispc_power_ctl
`default_nettype wire

// ===== cispc_pkg.sv
/*
  Package for the idle/stop power control block: register address, field
  positions, reset values, mode enumeration and the carrier structs.
  Assumes a special-function register port driven by the core, one clock.
*/
// Overview of operation
// - Writing 1 to idle bit gates cpu clock; peripheral clocks keep running.
// - During idle no cpu register or memory write enable is given.
// - Idle ends only on enabled interrupt or reset.
// - Interrupt wake clears idle bit, restarts cpu clock, lets interrupt be serviced.
// - After interrupt return execution continues after the idle-setting instruction.
// - Reset ending idle runs normal reset sequence, fetch from 0x0000.
// - Enabled watchdog counts during idle; overflow reset ends idle.
// - Writing 1 to stop bit halts cpu and internal oscillators.
// - In stop, interrupts and timers inactive; clock loss detector keeps running.
// - Only a reset ends stop; normal reset sequence, start at 0x0000.
// - Enabled clock loss detector reset ends stop; software disables it for long sleeps.
// - Reads of stop and idle bits always return 0.
// - Control register at address 0x87 on every page, reset value zero.
`default_nettype none
package cispc_pkg;
  localparam logic [7:0]  CISPC_PMC_ADDR   = 8'h87;
  localparam logic [7:0]  CISPC_PMC_RESET  = 8'h00;
  localparam int          CISPC_IDLE_BIT   = 0;
  localparam int          CISPC_STOP_BIT   = 1;
  localparam logic [15:0] CISPC_RESET_VEC  = 16'h0000;
  localparam int          CISPC_LOSS_TIMEOUT_US  = 100;
  localparam int          CISPC_CLK_MHZ          = 25;
  localparam int          CISPC_LOSS_TIMEOUT_CYC = CISPC_LOSS_TIMEOUT_US * CISPC_CLK_MHZ;

  typedef enum logic [1:0] {CISPC_RUN, CISPC_IDLE, CISPC_STOP} cispc_mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       instr_done;
  } cispc_sfr_req_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic osc_en;
    logic periph_clk_en;
    logic irq_timer_en;
    logic cpu_wr_en;
  } cispc_gate_t;
endpackage : cispc_pkg
`default_nettype wire

// ===== cispc_power_ctl_test.sv
/*
  Self-checking bench for the idle/stop power controller.
  Assumes cispc_pkg and cispc_power_ctl are compiled first; one clock.
*/
`default_nettype none
module cispc_power_ctl_test import cispc_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // signals
  logic           clk_in    = 1'b0;
  logic           rst_n_in  = 1'b0;
  logic           irq       = 1'b0;
  logic           ext_pin_n = 1'b1;
  logic           wdog      = 1'b0;
  logic           clk_loss  = 1'b0;
  cispc_sfr_req_t sfr       = '0;
  logic [7:0]     sfr_rdata_out;
  logic           sfr_hit_out;
  cispc_gate_t    gate_out;
  cispc_mode_t    mode_out;
  logic           core_reset_out;
  logic [15:0]    fetch_vec_out;
  logic           irq_wake_out;
  int             err_total = 0;
  int             total_checks = 0;
  int             d;

  always #20 clk_in = ~clk_in;

  cispc_power_ctl DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .sfr_in(sfr),
    .sfr_rdata_out(sfr_rdata_out), .sfr_hit_out(sfr_hit_out),
    .irq_enabled_pending_in(irq), .ext_reset_n_pin_in(ext_pin_n),
    .watchdog_unit_ovf_in(wdog), .clock_loss_detector_fire_in(clk_loss),
    .gate_out(gate_out), .mode_out(mode_out), .core_reset_out(core_reset_out),
    .fetch_vec_out(fetch_vec_out), .irq_wake_out(irq_wake_out));
  // ==========================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // model: run=0 idle=1 stop=2; stop wins when both bits set
  function automatic int next_m(input int v);
    return (v & 2) ? 2 : ((v & 1) ? 1 : 0);
  endfunction : next_m

  task automatic chk_mode(input int m);
    chk(16'(mode_out), 16'(m));
    chk(16'(gate_out), {11'h0, m == 0, m != 2, m != 2, m != 2, m == 0});
  endtask : chk_mode

  task automatic wr_pmc(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    sfr.wr    <= 1'b1;
    sfr.addr  <= a;
    sfr.wdata <= v;
    @(posedge clk_in);
    sfr.wr         <= 1'b0;
    sfr.instr_done <= 1'b1;
    #1 chk(16'(sfr_hit_out), 16'(a == CISPC_PMC_ADDR));
    @(posedge clk_in);
    sfr.instr_done <= 1'b0;
    #1;
  endtask : wr_pmc

  task automatic rd_chk;
    @(posedge clk_in);
    sfr.rd   <= 1'b1;
    sfr.addr <= CISPC_PMC_ADDR;
    @(posedge clk_in);
    sfr.rd <= 1'b0;
    #1 chk(16'(sfr_rdata_out), 16'h0000);
  endtask : rd_chk

  // source 0 pin, 1 watchdog, 2 clock loss; held long enough for the synchroniser
  task automatic rst_src(input int s);
    @(posedge clk_in);
    ext_pin_n <= (s != 0);
    wdog      <= (s == 1);
    clk_loss  <= (s == 2);
    repeat (6) @(posedge clk_in);
    #1 chk(16'(core_reset_out), 16'h0001);
    chk_mode(0);
    chk(fetch_vec_out, CISPC_RESET_VEC);
    @(posedge clk_in);
    ext_pin_n <= 1'b1;
    wdog      <= 1'b0;
    clk_loss  <= 1'b0;
    repeat (6) @(posedge clk_in);
    #1 chk(16'(core_reset_out), 16'h0000);
  endtask : rst_src

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  // ==========================================
  // sequence
  initial begin
    d = $urandom(32'h80a88d9d);
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1 chk_mode(0);
    rd_chk();
    $display("reset test done");
    wr_pmc(CISPC_PMC_ADDR, 8'h01);
    chk_mode(1);
    @(posedge clk_in);
    irq <= 1'b1;
    @(posedge clk_in);
    irq <= 1'b0;
    #1 chk_mode(0);
    chk(16'(irq_wake_out), 16'h0001);
    @(posedge clk_in);
    #1 chk(16'(irq_wake_out), 16'h0000);
    $display("idle test done");
    wr_pmc(CISPC_PMC_ADDR, 8'h02);
    chk_mode(2);
    @(posedge clk_in);
    irq <= 1'b1;
    repeat (3) @(posedge clk_in);
    irq <= 1'b0;
    #1 chk_mode(2);
    rst_src(1);
    wr_pmc(CISPC_PMC_ADDR, 8'h03);
    chk_mode(2);
    rst_src(2);
    wr_pmc(8'h86, 8'h01);
    chk_mode(0);
    wr_pmc(CISPC_PMC_ADDR, 8'h01);
    chk_mode(1);
    rst_src(0);
    $display("stop and reset tests done");
    repeat (12) begin
      d = $urandom;
      wr_pmc(CISPC_PMC_ADDR, d[7:0]);
      chk_mode(next_m(d));
      rst_src(1);
    end
    $display("random test done");
    end_of_test();
  end

  // whole run needs well under 1000 cycles
  initial begin
    #(40 * 4000);
    err_total++;
    end_of_test();
  end
endmodule : cispc_power_ctl_test
`default_nettype wire
